// >>> logic/sublayer_receiver.v
// Function
// - Data header needs extended field 00
// - Honour sequence-valid flag
// - Ignore reserved bit and byte
// - Decode flow identifier; one stream flow
// - Accept one to seven stream packets
// - Drop null stream packets
// - Segment count equals table entries
// - Entries carry begin, end, length
// - Reassemble split frames across packets
// - Latency header: field 01, seq flag 0
// - Code values 0..3, rest reserved
// - Copy transaction identifier into reply
// - Answer ingress requests, one at once
// - End timestamp from sync timebase
// - Ingress stamp before queueing
// - Return completed reply to core
// - Drop egress requests silently
// - Discard nonconforming headers
// Receiver side of the pseudowire sub-layer: parses headers, queues payload,
// answers latency requests. Assumes byte stream from the tunnel decapsulator.
`timescale 1ns/10ps
`include "sublayer_consts.vh"
module sublayer_receiver (
   // Clock and reset
   input  wire        mclk,
   input  wire        resetn,
   // Session setup
   input  wire        session_mode,
   input  wire        session_active,
   input  wire [31:0] sync_timebase,
   // Incoming packet bytes
   input  wire        rx_valid,
   input  wire        rx_start,
   input  wire        rx_end,
   input  wire [7:0]  rx_data,
   output reg         rx_ready,
   // Payload toward queues
   output reg         q_valid,
   input  wire        q_ready,
   output reg  [7:0]  q_data,
   output reg         q_frame_start,
   output reg         q_frame_end,
   // Reply toward core
   output reg         reply_valid,
   output reg  [7:0]  reply_data,
   output reg         reply_last,
   // Status
   output reg         header_discard,
   output reg         sequence_gap,
   output reg  [2:0]  flow_identifier
);
   localparam ST_HDR   = 6'h01;
   localparam ST_TABLE = 6'h02;
   localparam ST_TS    = 6'h04;
   localparam ST_PS    = 6'h08;
   localparam ST_LAT   = 6'h10;
   localparam ST_DROP  = 6'h20;

   reg  [5:0]  state;
   reg  [3:0]  hcnt;
   reg  [7:0]  hdr0;
   reg  [7:0]  hdr1;
   reg  [7:0]  code;
   reg  [7:0]  transaction;
   reg  [31:0] stamp_start;
   reg  [31:0] stamp_end;
   reg  [15:0] seq_hold;
   reg  [15:0] seq_expect;
   reg         seq_known;
   reg  [6:0]  seg_total;
   reg  [6:0]  seg_idx;
   reg  [15:0] seg_table [0:127];
   reg  [13:0] seg_left;
   reg  [7:0]  ts_byte;
   reg  [2:0]  ts_count;
   reg         ts_null;
   reg  [7:0]  ts_pid_hi;
   reg         reply_start;
   reg         in_frame;
   reg  [4:0]  fill;

   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [9:0]  fifo_out_data;
   wire        take;
   wire        payload_push;
   wire        fifo_pop;
   wire [4:0]  next_fill;
   reg  [9:0]  payload_word;
   wire        rb_busy;
   wire        rb_valid;
   wire [7:0]  rb_data;
   wire        rb_last;

   // Header byte 0 checks: V=0, extended field (sequence flag is tested by the caller)
   function hdr_ok;
      input [7:0] b;
      input [1:0] ext;
      begin
         hdr_ok = (b[7] == 1'b0) && (b[5:4] == ext);
      end
   endfunction

   assign take = rx_valid && rx_ready;
   assign payload_push = take && !rx_start && (state == ST_PS || (state == ST_TS && !ts_null && ts_byte > 8'h2));
   assign fifo_pop     = fifo_out_valid && (q_ready || !q_valid);
   // Occupancy one step ahead keeps the registered ready exact
   assign next_fill    = fill + {4'h0, payload_push && fifo_in_ready} - {4'h0, fifo_pop};

   always @* begin
      payload_word = {1'b0, 1'b0, rx_data};
      if (state == ST_PS) begin
         payload_word[9] = (seg_left == seg_table[seg_idx][13:0]) && seg_table[seg_idx][15];
         payload_word[8] = (seg_left == 14'h1) && seg_table[seg_idx][14];
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state          <= ST_HDR;
         hcnt           <= 4'h0;
         hdr0           <= 8'h00;
         hdr1           <= 8'h00;
         code           <= 8'h00;
         transaction    <= 8'h00;
         stamp_start    <= 32'h0;
         stamp_end      <= 32'h0;
         seq_hold       <= 16'h0;
         seq_expect     <= 16'h0;
         seq_known      <= 1'b0;
         seg_total      <= 7'h0;
         seg_idx        <= 7'h0;
         seg_left       <= 14'h0;
         ts_byte        <= 8'h00;
         ts_count       <= 3'h0;
         ts_null        <= 1'b0;
         ts_pid_hi      <= 8'h00;
         reply_start    <= 1'b0;
         in_frame       <= 1'b0;
         rx_ready       <= 1'b0;
         fill           <= 5'h00;
         header_discard <= 1'b0;
         sequence_gap   <= 1'b0;
         flow_identifier <= 3'h0;
      end else begin
         rx_ready       <= (next_fill != 5'h10);
         fill           <= next_fill;
         reply_start    <= 1'b0;
         header_discard <= 1'b0;
         sequence_gap   <= 1'b0;
         if (take && rx_start) begin
            hdr0 <= rx_data;
            hcnt <= 4'h1;
            state <= ST_HDR;
         end else if (take) begin
            case (state)
               ST_HDR: begin
                  hcnt <= hcnt + 4'h1;
                  if (hcnt == 4'h1) begin
                     hdr1 <= rx_data;
                     flow_identifier <= hdr0[2:0];
                     if (hdr_ok(hdr0, `EXT_HDR_LATENCY) && !hdr0[6] && session_active) begin
                        state <= ST_LAT;
                     end else if (!hdr_ok(hdr0, `EXT_HDR_DATA) || !session_active) begin
                        state <= ST_DROP;
                        header_discard <= 1'b1;
                     end else if (session_mode == `MODE_PS) begin
                        seg_total <= rx_data[6:0];
                     end
                  end else if (hcnt == 4'h2) begin
                     seq_hold[15:8] <= rx_data;
                  end else begin
                     seq_hold[7:0] <= rx_data;
                     if (hdr0[6]) begin
                        seq_known  <= 1'b1;
                        seq_expect <= {seq_hold[15:8], rx_data} + 16'h1;
                        sequence_gap <= seq_known && ({seq_hold[15:8], rx_data} != seq_expect);
                     end
                     seg_idx  <= 7'h0;
                     ts_byte  <= 8'h00;
                     ts_count <= 3'h0;
                     if (session_mode == `MODE_PS) begin
                        state <= (seg_total == 7'h0) ? ST_DROP : ST_TABLE;
                        header_discard <= (seg_total == 7'h0);
                     end else begin
                        state <= ST_TS;
                     end
                  end
               end
               ST_TABLE: begin
                  hcnt <= hcnt + 4'h1;
                  if (hcnt[0]) begin
                     seg_table[seg_idx] <= {hdr1, rx_data};
                     if (seg_idx == seg_total - 7'h1) begin
                        seg_idx <= 7'h0;
                        seg_left <= (seg_total != 7'h1) ? seg_table[7'h0][13:0] :
                                    (hdr1[5:0] == 6'h0 && rx_data == 8'h0) ? 14'h1 : {hdr1[5:0], rx_data};
                        state <= ST_PS;
                     end else begin
                        seg_idx <= seg_idx + 7'h1;
                     end
                  end else begin
                     hdr1 <= rx_data;
                  end
               end
               ST_PS: begin
                  if (seg_left == 14'h1) begin
                     seg_idx  <= seg_idx + 7'h1;
                     seg_left <= seg_table[seg_idx + 7'h1][13:0];
                     if (seg_table[seg_idx][14]) begin
                        in_frame <= 1'b0;
                     end
                  end else begin
                     seg_left <= seg_left - 14'h1;
                     if (seg_table[seg_idx][15]) begin
                        in_frame <= 1'b1;
                     end
                  end
               end
               ST_TS: begin
                  ts_byte <= (ts_byte == `TS_PACKET_LEN - 8'h1) ? 8'h00 : ts_byte + 8'h1;
                  if (ts_byte == 8'h1) begin
                     ts_pid_hi <= rx_data;
                  end else if (ts_byte == 8'h2) begin
                     ts_null <= (ts_pid_hi[4:0] == `NULL_PID_HI) && (rx_data == `NULL_PID_LO);
                  end else if (ts_byte == `TS_PACKET_LEN - 8'h1) begin
                     ts_null <= 1'b0;
                     if (ts_count == `TS_MAX_PACKETS - 3'h1) begin
                        state <= ST_DROP;
                     end
                     ts_count <= ts_count + 3'h1;
                  end
               end
               ST_LAT: begin
                  hcnt <= hcnt + 4'h1;
                  if (hcnt == 4'h2) begin
                     code <= rx_data;
                  end else if (hcnt == 4'h3) begin
                     transaction <= rx_data;
                  end else if (hcnt >= 4'h4 && hcnt <= 4'h7) begin
                     stamp_start <= {stamp_start[23:0], rx_data};
                     if (hcnt == 4'h7) begin
                        stamp_end <= sync_timebase;
                        reply_start <= (code == `CODE_INGRESS_REQ) && session_active && !rb_busy;
                        state <= ST_DROP;
                     end
                  end
               end
               default: begin
                  state <= state;
               end
            endcase
         end
      end
   end

   // Payload FIFO toward the queues
   payload_fifo #(
      .WIDTH  (`FIFO_WIDTH),
      .DEPTH  (`FIFO_DEPTH),
      .ADDR_W (`FIFO_ADDR_W)
   ) fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (payload_push),
      .in_ready  (fifo_in_ready),
      .in_data   (payload_word),
      .out_valid (fifo_out_valid),
      .out_ready (q_ready || !q_valid),
      .out_data  (fifo_out_data)
   );

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q_valid       <= 1'b0;
         q_data        <= 8'h00;
         q_frame_start <= 1'b0;
         q_frame_end   <= 1'b0;
         reply_valid   <= 1'b0;
         reply_data    <= 8'h00;
         reply_last    <= 1'b0;
      end else begin
         if (q_ready || !q_valid) begin
            q_valid       <= fifo_out_valid;
            q_data        <= fifo_out_data[7:0];
            q_frame_start <= fifo_out_data[9];
            q_frame_end   <= fifo_out_data[8];
         end
         reply_valid <= rb_valid;
         reply_data  <= rb_data;
         reply_last  <= rb_last;
      end
   end

   reply_builder replies (
      .mclk            (mclk),
      .resetn          (resetn),
      .start           (reply_start),
      .flow_identifier (flow_identifier),
      .code            (`CODE_INGRESS_REP),
      .transaction     (transaction),
      .stamp_start     (stamp_start),
      .stamp_end       (stamp_end),
      .busy            (rb_busy),
      .byte_valid      (rb_valid),
      .byte_data       (rb_data),
      .byte_last       (rb_last)
   );
endmodule

// >>> logic/sublayer_consts.vh
// Constants for the pseudowire sub-layer receiver.
// Assumes a byte-wide packet stream framed by start and end strobes.
`ifndef SUBLAYER_CONSTS_VH
`define SUBLAYER_CONSTS_VH
`define EXT_HDR_DATA      2'h0
`define EXT_HDR_LATENCY   2'h1
`define CODE_INGRESS_REQ  8'h00
`define CODE_INGRESS_REP  8'h01
`define CODE_EGRESS_REQ   8'h02
`define CODE_EGRESS_REP   8'h03
`define MODE_TS           1'b0
`define MODE_PS           1'b1
`define TS_PACKET_LEN     8'hBC
`define TS_MAX_PACKETS    3'h7
`define TS_SYNC_BYTE      8'h47
`define NULL_PID_HI       5'h1F
`define NULL_PID_LO       8'hFF
`define LATENCY_HDR_LEN   4'hC
`define FIFO_WIDTH        10
`define FIFO_DEPTH        16
`define FIFO_ADDR_W       4
`endif

// >>> logic/payload_fifo.v
// Payload FIFO, flip-flop storage, valid/ready on both sides.
// Assumes one clock domain shared with the receiver.
`timescale 1ns/10ps
module payload_fifo #(
   parameter WIDTH  = 10,
   parameter DEPTH  = 16,
   parameter ADDR_W = 4
) (
   // Clock and reset
   input  wire              mclk,
   input  wire              resetn,
   // Fill side
   input  wire              in_valid,
   output wire              in_ready,
   input  wire [WIDTH-1:0]  in_data,
   // Drain side
   output wire              out_valid,
   input  wire              out_ready,
   output wire [WIDTH-1:0]  out_data
);
   reg  [WIDTH-1:0]  mem [0:DEPTH-1];
   reg  [ADDR_W-1:0] wr_ptr;
   reg  [ADDR_W-1:0] rd_ptr;
   reg  [ADDR_W:0]   count;
   wire              push;
   wire              pop;

   assign in_ready  = (count != DEPTH[ADDR_W:0]);
   assign out_valid = (count != {(ADDR_W+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= {ADDR_W{1'b0}};
         rd_ptr <= {ADDR_W{1'b0}};
         count  <= {(ADDR_W+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// >>> logic/reply_builder.v
// Latency reply serialiser: emits a 12-byte reply header.
// Assumes fields are held stable while busy is high.
`timescale 1ns/10ps
`include "sublayer_consts.vh"
module reply_builder (
   // Clock and reset
   input  wire        mclk,
   input  wire        resetn,
   // Request
   input  wire        start,
   input  wire [2:0]  flow_identifier,
   input  wire [7:0]  code,
   input  wire [7:0]  transaction,
   input  wire [31:0] stamp_start,
   input  wire [31:0] stamp_end,
   output reg         busy,
   // Byte output
   output reg         byte_valid,
   output reg  [7:0]  byte_data,
   output reg         byte_last
);
   reg [3:0]  idx;
   reg [7:0]  next_byte;

   always @* begin
      case (idx)
         4'h0: next_byte = {1'b0, 1'b0, `EXT_HDR_LATENCY, 1'b0, flow_identifier};
         4'h1: next_byte = 8'h00;
         4'h2: next_byte = code;
         4'h3: next_byte = transaction;
         4'h4: next_byte = stamp_start[31:24];
         4'h5: next_byte = stamp_start[23:16];
         4'h6: next_byte = stamp_start[15:8];
         4'h7: next_byte = stamp_start[7:0];
         4'h8: next_byte = stamp_end[31:24];
         4'h9: next_byte = stamp_end[23:16];
         4'hA: next_byte = stamp_end[15:8];
         4'hB: next_byte = stamp_end[7:0];
         default: next_byte = 8'h00;
      endcase
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy       <= 1'b0;
         idx        <= 4'h0;
         byte_valid <= 1'b0;
         byte_data  <= 8'h00;
         byte_last  <= 1'b0;
      end else begin
         byte_valid <= busy;
         byte_data  <= next_byte;
         byte_last  <= busy && (idx == `LATENCY_HDR_LEN - 4'h1);
         if (start && !busy) begin
            busy <= 1'b1;
            idx  <= 4'h0;
         end else if (busy) begin
            if (idx == `LATENCY_HDR_LEN - 4'h1) begin
               busy <= 1'b0;
            end
            idx <= idx + 4'h1;
         end
      end
   end
endmodule

// >>> verif/sublayer_receiver_props.sv
// Checker for the sub-layer receiver outputs.
// Assumes a bind onto sublayer_receiver, one clock domain.
`timescale 1ns/10ps
module sublayer_receiver_props (
   // Clock and reset
   input wire       mclk,
   input wire       resetn,
   // Payload side
   input wire       q_valid,
   input wire       q_ready,
   input wire [7:0] q_data,
   // Reply side
   input wire       reply_valid,
   input wire [7:0] reply_data,
   input wire       reply_last,
   // Status
   input wire       header_discard,
   input wire       sequence_gap,
   input wire [2:0] flow_identifier
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_body;
      (reply_valid && !reply_last) [*8];
   endsequence
   sequence s_tail;
      (reply_valid && !reply_last) [*3] ##1 (reply_valid && reply_last);
   endsequence
   property p_q_hold;
      q_valid && !q_ready |=> q_valid && $stable(q_data);
   endproperty
   a_q_hold: assert property (p_q_hold) else $error("payload changed while stalled");
   property p_reply_len;
      $rose(reply_valid) |-> s_body ##1 s_tail;
   endproperty
   a_reply_len: assert property (p_reply_len) else $error("reply length not twelve");
   property p_reply_hdr;
      $rose(reply_valid) |-> reply_data[7:3] == 5'h02;
   endproperty
   a_reply_hdr: assert property (p_reply_hdr) else $error("reply header flags wrong");
   property p_reply_flow;
      $rose(reply_valid) |-> reply_data[2:0] == flow_identifier;
   endproperty
   a_reply_flow: assert property (p_reply_flow) else $error("reply flow wrong");
   property p_reply_rsvd;
      $rose(reply_valid) |=> reply_data == 8'h00;
   endproperty
   a_reply_rsvd: assert property (p_reply_rsvd) else $error("reply reserved byte not zero");
   property p_reply_code;
      $rose(reply_valid) |-> ##2 reply_data == 8'h01;
   endproperty
   a_reply_code: assert property (p_reply_code) else $error("reply code wrong");
   property p_reply_one;
      reply_last |=> !reply_valid;
   endproperty
   a_reply_one: assert property (p_reply_one) else $error("reply runs past last byte");
   property p_disc_pulse;
      header_discard |=> !header_discard;
   endproperty
   a_disc_pulse: assert property (p_disc_pulse) else $error("discard pulse too long");
   property p_gap_pulse;
      sequence_gap |=> !sequence_gap;
   endproperty
   a_gap_pulse: assert property (p_gap_pulse) else $error("gap pulse too long");
endmodule

// >>> verif/core_engine_model.sv
// Behavioural sending core: presents queued bytes on the receiver input.
// Assumes the bench pushes whole packets; stall paces the stream.
`timescale 1ns/10ps
module core_engine_model (
   // Clock and reset
   input  wire       mclk,
   input  wire       resetn,
   // Pacing
   input  wire       stall,
   // Byte stream
   output reg        rx_valid,
   output reg        rx_start,
   output reg        rx_end,
   output reg  [7:0] rx_data,
   input  wire       rx_ready
);
   reg [9:0] pend[$];
   reg       took;
   task push(input [9:0] w);
      pend.push_back(w);
   endtask
   initial begin
      rx_valid = 1'b0;
      rx_start = 1'b0;
      rx_end = 1'b0;
      rx_data = 8'h00;
      took = 1'b0;
   end
   always @(posedge mclk) took <= rx_valid && rx_ready;
   always @(negedge mclk) begin
      if (took) pend.pop_front();
      if (took || !rx_valid) begin
         if (pend.size() > 0 && !stall && resetn) begin
            rx_valid <= 1'b1;
            {rx_end, rx_start, rx_data} <= pend[0];
         end else begin
            rx_valid <= 1'b0;
            rx_start <= 1'b0;
            rx_end <= 1'b0;
            rx_data <= ~rx_data;
         end
      end
   end
endmodule

// >>> verif/sublayer_receiver_tb_top.sv
// Self-checking bench for the sub-layer receiver.
// Assumes core_engine_model as sender and a bound property checker.
`timescale 1ns/10ps
module sublayer_receiver_tb_top;
   reg         mclk, resetn, session_mode, session_active, q_ready, stall, hold_q;
   reg  [31:0] sync_timebase, rs, rq;
   wire        rx_valid, rx_start, rx_end, rx_ready, q_valid, q_frame_start, q_frame_end;
   wire        reply_valid, reply_last, header_discard, sequence_gap;
   wire [7:0]  rx_data, q_data, reply_data;
   wire [2:0]  flow_identifier;
   reg  [10:0] exp_q[$];
   reg  [8:0]  exp_r[$];
   reg  [10:0] w;
   reg  [8:0]  r;
   reg  [15:0] seq;
   reg  [7:0]  b;
   integer     fail_count, check_count, disc_seen, gap_seen, disc_exp, i, k;

   core_engine_model core (.mclk(mclk), .resetn(resetn), .stall(stall), .rx_valid(rx_valid),
      .rx_start(rx_start), .rx_end(rx_end), .rx_data(rx_data), .rx_ready(rx_ready));
   sublayer_receiver uut (.mclk(mclk), .resetn(resetn), .session_mode(session_mode),
      .session_active(session_active), .sync_timebase(sync_timebase), .rx_valid(rx_valid),
      .rx_start(rx_start), .rx_end(rx_end), .rx_data(rx_data), .rx_ready(rx_ready),
      .q_valid(q_valid), .q_ready(q_ready), .q_data(q_data), .q_frame_start(q_frame_start),
      .q_frame_end(q_frame_end), .reply_valid(reply_valid), .reply_data(reply_data),
      .reply_last(reply_last), .header_discard(header_discard), .sequence_gap(sequence_gap),
      .flow_identifier(flow_identifier));

   always #25 mclk = ~mclk;

   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task rnd;
      rs = xs(rs);
   endtask
   task compare(input [8*10-1:0] nm, input [31:0] e, input [31:0] s);
      begin
         check_count = check_count + 1;
         if (e !== s) begin
            fail_count = fail_count + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task put(input [7:0] d, input s);
      core.push({1'b0, s, d});
   endtask
   task hdr(input [7:0] h0, input [7:0] h1, input [15:0] sq);
      begin
         put(h0, 1'b1);
         put(h1, 1'b0);
         put(sq[15:8], 1'b0);
         put(sq[7:0], 1'b0);
      end
   endtask
   task bad(input [7:0] h0);
      begin
         hdr(h0, 8'h01, 16'h0000);
         put(8'h47, 1'b0);
         disc_exp = disc_exp + 1;
      end
   endtask
   task ts_pkt(input [2:0] fl, input integer n, input [7:0] nulls, input s);
      begin
         if (s) seq = seq + 16'h0001;
         rnd;
         hdr({1'b0, s, 2'b00, rs[8], fl}, rs[7:0], s ? seq : rs[31:16]);
         for (i = 0; i < n; i = i + 1)
            for (k = 0; k < 188; k = k + 1) begin
               rnd;
               b = (k == 0) ? 8'h47 : (k == 1) ? (nulls[i] ? 8'h1F : 8'h01) :
                   (k == 2 && nulls[i]) ? 8'hFF : rs[7:0];
               put(b, 1'b0);
               if (k > 2 && !nulls[i]) exp_q.push_back({3'b000, b});
            end
      end
   endtask
   task lat_pkt(input [2:0] fl, input [7:0] code);
      reg [63:0] qb;
      reg [95:0] rp;
      integer    j;
      begin
         rnd;
         sync_timebase = rs;
         rnd;
         qb = {5'h02, fl, 8'h00, code, rs[15:8], rs};
         rp = {qb[63:48], 8'h01, qb[39:0], sync_timebase};
         for (j = 0; j < 8; j++) put(qb[63-8*j -: 8], j == 0);
         if (code == 8'h00)
            for (j = 0; j < 12; j++) exp_r.push_back({j == 11, rp[95-8*j -: 8]});
      end
   endtask
   task ps_pkt(input [6:0] cnt, input [15:0] e0, input [15:0] e1);
      reg [15:0] e;
      integer    j;
      begin
         seq = seq + 16'h0001;
         hdr(8'h40, {1'b0, cnt}, seq);
         for (j = 0; j < cnt; j++) begin
            e = j ? e1 : e0;
            put(e[15:8], 1'b0);
            put(e[7:0], 1'b0);
         end
         for (j = 0; j < cnt; j++) begin
            e = j ? e1 : e0;
            for (k = 0; k < e[13:0]; k++) begin
               rnd;
               put(rs[7:0], 1'b0);
               exp_q.push_back({1'b1, e[15] && k == 0, e[14] && k == e[13:0] - 1, rs[7:0]});
            end
         end
      end
   endtask
   task drain;
      integer n;
      begin
         n = 0;
         while ((core.pend.size() + exp_q.size() + exp_r.size()) > 0 && n < 4000) begin
            @(negedge mclk);
            n++;
         end
         if (n == 4000) compare("drain", 0, 1);
         repeat (20) @(negedge mclk);
      end
   endtask

   always @(negedge mclk) begin
      rq = xs(rq);
      q_ready <= !hold_q && rq[1:0] != 2'b00;
      stall <= rq[4:2] == 3'b000;
   end

   always @(posedge mclk) if (resetn) begin
      if (q_valid && q_ready) begin
         if (exp_q.size() == 0) compare("q_extra", 0, 1);
         else begin
            w = exp_q.pop_front();
            compare("q_data", w[7:0], q_data);
            compare("q_flags", w[9:8], {q_frame_start, q_frame_end});
         end
      end
      if (reply_valid) begin
         if (exp_r.size() == 0) compare("reply_xtra", 0, 1);
         else begin
            r = exp_r.pop_front();
            compare("reply", r, {reply_last, reply_data});
         end
      end
      if (header_discard === 1'b1) disc_seen = disc_seen + 1;
      if (sequence_gap === 1'b1) gap_seen = gap_seen + 1;
   end

   initial begin
      #(50 * 60000);
      fail_count = fail_count + 1;
      close_out;
   end

   initial begin
      mclk = 1'b0; resetn = 1'b0; session_mode = 1'b0; session_active = 1'b1;
      sync_timebase = 32'h0; q_ready = 1'b0; stall = 1'b0; hold_q = 1'b0;
      rs = 32'h6130d0b8; rq = xs(32'h6130d0b8); seq = rs[15:0];
      fail_count = 0; check_count = 0; disc_seen = 0; gap_seen = 0; disc_exp = 0;
      repeat (5) @(negedge mclk);
      resetn = 1'b1;
      ts_pkt(3'h0, 7, 8'h04, 1'b1);
      ts_pkt(3'h0, 1, 8'h01, 1'b1);
      hold_q = 1'b1;
      ts_pkt(3'h0, 2, 8'h00, 1'b1);
      repeat (300) @(negedge mclk);
      compare("rx_ready", 0, rx_ready);
      hold_q = 1'b0;
      drain;
      seq = seq + 16'h0001;
      ts_pkt(3'h0, 1, 8'h00, 1'b1);
      ts_pkt(3'h0, 1, 8'h00, 1'b0);
      ts_pkt(3'h0, 1, 8'h00, 1'b1);
      drain;
      bad(8'hC0);
      bad(8'h20);
      bad(8'h30);
      drain;
      session_active = 1'b0;
      bad(8'h40);
      bad(8'h10);
      drain;
      session_active = 1'b1;
      // ingress request per flow, one outstanding
      for (i = 0; i < 8; i++) begin
         lat_pkt(i[2:0], 8'h00);
         drain;
      end
      lat_pkt(3'h3, 8'h01);
      lat_pkt(3'h3, 8'h02);
      lat_pkt(3'h3, 8'h03);
      lat_pkt(3'h3, 8'h04);
      lat_pkt(3'h3, 8'hFF);
      drain;
      session_mode = 1'b1;
      ps_pkt(7'd2, {2'b11, 14'd3}, {2'b10, 14'd2});
      ps_pkt(7'd1, {2'b00, 14'd4}, 16'h0000);
      ps_pkt(7'd1, {2'b01, 14'd2}, 16'h0000);
      drain;
      ps_pkt(7'd0, 16'h0000, 16'h0000);
      disc_exp = disc_exp + 1;
      drain;
      lat_pkt(3'h0, 8'h00);
      drain;
      compare("discards", disc_exp, disc_seen);
      compare("gaps", 1, gap_seen);
      close_out;
   end
endmodule

bind sublayer_receiver sublayer_receiver_props chk (.mclk(mclk), .resetn(resetn), .q_valid(q_valid),
   .q_ready(q_ready), .q_data(q_data), .reply_valid(reply_valid), .reply_data(reply_data),
   .reply_last(reply_last), .header_discard(header_discard), .sequence_gap(sequence_gap),
   .flow_identifier(flow_identifier));
